// file: hdl/fpd_regs.vh
`ifndef FPD_REGS_VH
`define FPD_REGS_VH

// ****************************************
// pulse mode codes
// ****************************************
`define FPD_MODE_OFF      3'h0
`define FPD_MODE_UNI      3'h1
`define FPD_MODE_PULSEDIR 3'h2
`define FPD_MODE_FWDREV   3'h3
`define FPD_MODE_QUAD     3'h4

// ****************************************
// storage type codes
// ****************************************
`define FPD_STORE_NET     1'b0
`define FPD_STORE_INDEP   1'b1

// ****************************************
// widths and defaults
// ****************************************
`define FPD_CNT_W         16
`define FPD_CHAN_W        5
`define FPD_DIV_DEFAULT   16'h0032
`define FPD_DIV_W         16
`define FPD_STAT_W        24

`endif

// file: hdl/fpd_flow_pulse_decoder.v
`timescale 1ns/10ps
`include "fpd_regs.vh"

// How it works
// [RQ1] uni mode: each open-to-closed edge counts one
// [RQ2] two-pin functions claim the pair's even pin
// [RQ3] bi-directional modes only from the odd pin
// [RQ4] uni channel allowed on either pin
// [RQ5] even pin gives direction, odd pin pulses
// [RQ6] odd pin forward, even pin reverse pulses
// [RQ7] gray 00-01-11-10 steps count forward
// [RQ8] gray 00-10-11-01 steps count reverse
// [RQ9] quadrature gives net flow only
// [RQ10] forward/reverse pulse mode gives net only
// [RQ11] storage type only in pulse-direction mode
// [RQ12] net record is forward minus reverse count
// [RQ13] net writes one stream, configured channel tag
// [RQ14] independent: forward stream on odd channel
// [RQ15] reverse stream on next even channel
// [RQ16] each pin holds one function only
// [RQ17] shared configurable fast pin sample rate
// [RQ18] trigger drives status output for set time
// [RQ19] synchronise pins, ignore double-bit quad steps
// [RQ20] counters clear at each log boundary
module fpd_flow_pulse_decoder #(
	parameter CNT_W  = `FPD_CNT_W,
	parameter CHAN_W = `FPD_CHAN_W
) (
	// clock and reset
	input  wire                ref_clk_in,
	input  wire                nrst_in,
	// meter pins (level high = closed)
	input  wire                odd_meter_pin_in,
	input  wire                even_meter_pin_in,
	// configuration
	input  wire [2:0]          odd_mode_in,
	input  wire [2:0]          even_mode_in,
	input  wire                store_type_in,
	input  wire [CHAN_W-1:0]   odd_chan_in,
	input  wire [`FPD_DIV_W-1:0] sample_div_in,
	input  wire                log_tick_in,
	// status output trigger
	input  wire                trig_in,
	input  wire [`FPD_STAT_W-1:0] stat_dur_in,
	// datapoint stream
	input  wire                dp_ready_in,
	output reg                 dp_valid_out,
	output reg  [CHAN_W-1:0]   dp_chan_out,
	output reg  [CNT_W:0]      dp_value_out,
	// status
	output reg                 even_claimed_out,
	output reg                 cfg_err_out,
	output reg                 stat_out,
	output reg                 lost_out
);

	// ****************************************
	// configuration decode
	// ****************************************
	wire bi_mode = (odd_mode_in == `FPD_MODE_PULSEDIR) || (odd_mode_in == `FPD_MODE_FWDREV) ||
		(odd_mode_in == `FPD_MODE_QUAD); // RQ3
	// even pin only usable on its own when the odd pin leaves it free
	wire even_uni = !bi_mode && (even_mode_in == `FPD_MODE_UNI); // RQ2 RQ4 RQ16
	wire odd_uni  = (odd_mode_in == `FPD_MODE_UNI); // RQ4
	// independent only in pulse-direction; others forced to net
	wire indep = (odd_mode_in == `FPD_MODE_PULSEDIR) && (store_type_in == `FPD_STORE_INDEP); // RQ9 RQ10 RQ11
	wire bad_cfg = (odd_mode_in > `FPD_MODE_QUAD) || (even_mode_in > `FPD_MODE_UNI) ||
		(bi_mode && even_mode_in != `FPD_MODE_OFF); // RQ3 RQ16

	// ****************************************
	// sample rate divider
	// ****************************************
	reg  [`FPD_DIV_W-1:0] div_ff;
	reg                   smp_ff;
	always @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			div_ff <= {`FPD_DIV_W{1'b0}};
			smp_ff <= 1'b0;
		end else if (div_ff >= sample_div_in) begin // RQ17
			div_ff <= {`FPD_DIV_W{1'b0}};
			smp_ff <= 1'b1;
		end else begin
			div_ff <= div_ff + 1'b1;
			smp_ff <= 1'b0;
		end
	end

	// ****************************************
	// pin synchronisers and sampling
	// ****************************************
	reg [1:0] sy1_ff;
	reg [1:0] sy2_ff;
	reg [1:0] cur_ff;
	reg [1:0] prv_ff;
	reg       smpd_ff;
	// sy1 feeds only sy2; sampling is done on the clean copy
	always @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			sy1_ff  <= 2'h0;
			sy2_ff  <= 2'h0;
			cur_ff  <= 2'h0;
			prv_ff  <= 2'h0;
			smpd_ff <= 1'b0;
		end else begin
			sy1_ff  <= {even_meter_pin_in, odd_meter_pin_in}; // RQ19
			sy2_ff  <= sy1_ff;
			smpd_ff <= smp_ff;
			if (smp_ff) begin // RQ17
				cur_ff <= sy2_ff;
				prv_ff <= cur_ff;
			end
		end
	end

	// ****************************************
	// pulse and step decode
	// ****************************************
	wire odd_rise  = smpd_ff && cur_ff[0] && !prv_ff[0];
	wire even_rise = smpd_ff && cur_ff[1] && !prv_ff[1];
	// gray steps, bit1 = odd pin, bit0 = even pin as printed pair
	wire [1:0] qn = {cur_ff[0], cur_ff[1]};
	wire [1:0] qp = {prv_ff[0], prv_ff[1]};
	wire q_fwd = smpd_ff && ((qp == 2'h0 && qn == 2'h1) || (qp == 2'h1 && qn == 2'h3) ||
		(qp == 2'h3 && qn == 2'h2) || (qp == 2'h2 && qn == 2'h0)); // RQ7
	wire q_rev = smpd_ff && ((qp == 2'h0 && qn == 2'h2) || (qp == 2'h2 && qn == 2'h3) ||
		(qp == 2'h3 && qn == 2'h1) || (qp == 2'h1 && qn == 2'h0)); // RQ8 RQ19
	reg inc_fwd;
	reg inc_rev;
	always @* begin
		inc_fwd = 1'b0;
		inc_rev = 1'b0;
		case (odd_mode_in)
			`FPD_MODE_UNI: inc_fwd = odd_rise; // RQ1
			`FPD_MODE_PULSEDIR: begin
				// even level high taken as reverse
				inc_fwd = odd_rise && !cur_ff[1]; // RQ5
				inc_rev = odd_rise && cur_ff[1]; // RQ5
			end
			`FPD_MODE_FWDREV: begin
				inc_fwd = odd_rise; // RQ6
				inc_rev = even_rise; // RQ6
			end
			`FPD_MODE_QUAD: begin
				inc_fwd = q_fwd;
				inc_rev = q_rev;
			end
			default: inc_fwd = 1'b0;
		endcase
		if (bad_cfg) begin
			inc_fwd = 1'b0;
			inc_rev = 1'b0;
		end
	end
	wire inc_even = !bad_cfg && even_uni && even_rise; // RQ4

	// ****************************************
	// per-period counters
	// ****************************************
	reg [CNT_W-1:0] fwd_ff;
	reg [CNT_W-1:0] rev_ff;
	reg [CNT_W-1:0] evn_ff;
	// a pulse in the boundary cycle starts the new period, so none is lost
	always @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			fwd_ff <= {CNT_W{1'b0}};
			rev_ff <= {CNT_W{1'b0}};
			evn_ff <= {CNT_W{1'b0}};
		end else if (log_tick_in) begin // RQ20
			fwd_ff <= {{(CNT_W-1){1'b0}}, inc_fwd};
			rev_ff <= {{(CNT_W-1){1'b0}}, inc_rev};
			evn_ff <= {{(CNT_W-1){1'b0}}, inc_even};
		end else begin
			fwd_ff <= fwd_ff + {{(CNT_W-1){1'b0}}, inc_fwd};
			rev_ff <= rev_ff + {{(CNT_W-1){1'b0}}, inc_rev};
			evn_ff <= evn_ff + {{(CNT_W-1){1'b0}}, inc_even};
		end
	end

	// ****************************************
	// datapoint generation
	// ****************************************
	// up to two words per boundary; queued into a two-entry buffer
	reg              pend_ff;
	reg [CHAN_W-1:0] pchan_ff;
	reg [CNT_W:0]    pval_ff;
	wire odd_act = bi_mode || odd_uni;
	wire [CNT_W:0] net_val = {1'b0, fwd_ff} - {1'b0, rev_ff}; // RQ12
	wire [CHAN_W-1:0] even_chan = odd_chan_in + {{(CHAN_W-1){1'b0}}, 1'b1}; // RQ15

	// two-entry buffer
	reg [CHAN_W+CNT_W:0] buf_ff [0:1];
	reg [1:0]            cnt_ff;
	reg                  rd_ff;
	reg                  wr_ff;
	wire buf_full = (cnt_ff == 2'h2);
	reg              push;
	reg [CHAN_W-1:0] push_chan;
	reg [CNT_W:0]    push_val;
	reg              nxt_pend;
	reg [CHAN_W-1:0] nxt_pchan;
	reg [CNT_W:0]    nxt_pval;
	reg              tick_drop;
	always @* begin
		push      = 1'b0;
		push_chan = odd_chan_in;
		push_val  = net_val;
		nxt_pend  = pend_ff;
		nxt_pchan = pchan_ff;
		nxt_pval  = pval_ff;
		tick_drop = 1'b0;
		if (pend_ff && !buf_full) begin
			push      = 1'b1;
			push_chan = pchan_ff;
			push_val  = pval_ff;
			nxt_pend  = 1'b0;
		end
		if (log_tick_in && !bad_cfg) begin
			// a waiting reverse word keeps its slot; the period just ended is counted lost
			if (pend_ff && (odd_act || even_uni)) begin
				tick_drop = 1'b1;
			end else if (odd_act) begin
				if (indep) begin
					push_chan = odd_chan_in; // RQ14
					push_val  = {1'b0, fwd_ff}; // RQ14
					nxt_pchan = even_chan; // RQ15
					nxt_pval  = {1'b0, rev_ff}; // RQ15
					nxt_pend  = 1'b1;
				end else begin
					push_chan = odd_chan_in; // RQ13
					push_val  = net_val; // RQ12 RQ13
				end
				push = 1'b1;
			end else if (even_uni) begin
				push_chan = even_chan; // RQ4
				push_val  = {1'b0, evn_ff};
				push      = 1'b1;
			end
		end
	end

	// buffer pointers and data; a push into a full buffer is counted lost
	wire pop = dp_valid_out && dp_ready_in;
	wire do_push = push && !buf_full;
	always @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cnt_ff       <= 2'h0;
			rd_ff        <= 1'b0;
			wr_ff        <= 1'b0;
			pend_ff      <= 1'b0;
			pchan_ff     <= {CHAN_W{1'b0}};
			pval_ff      <= {(CNT_W+1){1'b0}};
			dp_valid_out <= 1'b0;
			dp_chan_out  <= {CHAN_W{1'b0}};
			dp_value_out <= {(CNT_W+1){1'b0}};
			lost_out     <= 1'b0;
		end else begin
			pend_ff  <= nxt_pend;
			pchan_ff <= nxt_pchan;
			pval_ff  <= nxt_pval;
			if (do_push) begin
				buf_ff[wr_ff] <= {push_chan, push_val};
				wr_ff <= ~wr_ff;
			end
			if (pop) begin
				rd_ff <= ~rd_ff;
			end
			cnt_ff <= cnt_ff + {1'b0, do_push} - {1'b0, pop};
			if ((push && buf_full) || tick_drop) begin
				lost_out <= 1'b1;
			end
			// output register refreshes from the buffer head
			if (!dp_valid_out || pop) begin
				if ((cnt_ff - {1'b0, pop}) != 2'h0) begin
					dp_valid_out <= 1'b1;
					{dp_chan_out, dp_value_out} <= buf_ff[pop ? ~rd_ff : rd_ff];
				end else begin
					dp_valid_out <= 1'b0;
				end
			end
		end
	end

	// ****************************************
	// status output and flags
	// ****************************************
	reg [`FPD_STAT_W-1:0] stat_cnt_ff;
	always @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			stat_cnt_ff      <= {`FPD_STAT_W{1'b0}};
			stat_out         <= 1'b0;
			even_claimed_out <= 1'b0;
			cfg_err_out      <= 1'b0;
		end else begin
			even_claimed_out <= bi_mode; // RQ2
			cfg_err_out      <= bad_cfg; // RQ16
			if (trig_in && stat_dur_in != {`FPD_STAT_W{1'b0}}) begin // RQ18
				stat_cnt_ff <= stat_dur_in;
				stat_out    <= 1'b1;
			end else if (stat_cnt_ff > {{(`FPD_STAT_W-1){1'b0}}, 1'b1}) begin
				stat_cnt_ff <= stat_cnt_ff - 1'b1;
			end else begin
				stat_cnt_ff <= {`FPD_STAT_W{1'b0}};
				stat_out    <= 1'b0; // RQ18
			end
		end
	end

endmodule

// file: dv/fpd_chk_sva.sv
`timescale 1ns/10ps
`include "fpd_regs.vh"
// ****
// port checker
// ****
module fpd_chk #(
	parameter CNT_W = 16,
	parameter CHAN_W = 5
) (
	// observed inputs
	input wire ref_clk_in,
	input wire nrst_in,
	input wire [2:0] odd_mode_in,
	input wire [2:0] even_mode_in,
	input wire store_type_in,
	input wire [CHAN_W-1:0] odd_chan_in,
	input wire log_tick_in,
	input wire trig_in,
	input wire [`FPD_STAT_W-1:0] stat_dur_in,
	input wire dp_ready_in,
	// observed outputs
	input wire dp_valid_out,
	input wire [CHAN_W-1:0] dp_chan_out,
	input wire [CNT_W:0] dp_value_out,
	input wire even_claimed_out,
	input wire cfg_err_out,
	input wire stat_out
);
	// odd pin owns the pair in these modes
	wire bi = odd_mode_in == 3'h2 || odd_mode_in == 3'h3 || odd_mode_in == 3'h4;
	wire indep = odd_mode_in == 3'h2 && store_type_in;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!nrst_in);
	// a tick into an empty buffer, and a stalled word
	sequence s_tick;
		log_tick_in && !dp_valid_out && !cfg_err_out && odd_mode_in != 3'h0;
	endsequence
	sequence s_stall;
		dp_valid_out && !dp_ready_in;
	endsequence
	claim_set_a: assert property (bi |-> ##[1:2] even_claimed_out)
		else $error("even pin not claimed");
	pair_err_a: assert property (bi && even_mode_in != 3'h0 |-> ##[1:2] cfg_err_out)
		else $error("pin given two functions");
	even_free_a: assert property (odd_mode_in == 3'h0 && even_mode_in == 3'h1
		|-> ##[1:2] !even_claimed_out && !cfg_err_out) else $error("even uni refused");
	stat_on_a: assert property (trig_in && stat_dur_in != 24'h000000 |-> ##[1:2] stat_out)
		else $error("status output not driven");
	word_hold_a: assert property (s_stall |=> dp_valid_out && $stable(dp_chan_out)
		&& $stable(dp_value_out)) else $error("stalled word changed");
	net_tag_a: assert property (dp_valid_out && bi && !indep
		|-> dp_chan_out == odd_chan_in) else $error("net word on wrong channel");
	indep_tag_a: assert property (dp_valid_out && indep
		|-> dp_chan_out == odd_chan_in || dp_chan_out == odd_chan_in + 1'b1)
		else $error("split word on wrong channel");
	tick_word_a: assert property (s_tick |-> ##[1:3] dp_valid_out)
		else $error("no word after log tick");
endmodule

bind fpd_flow_pulse_decoder fpd_chk #(.CNT_W(CNT_W), .CHAN_W(CHAN_W)) u_fpd_chk (
	.ref_clk_in, .nrst_in, .odd_mode_in, .even_mode_in, .store_type_in, .odd_chan_in,
	.log_tick_in, .trig_in, .stat_dur_in, .dp_ready_in, .dp_valid_out, .dp_chan_out,
	.dp_value_out, .even_claimed_out, .cfg_err_out, .stat_out);

// file: dv/fpd_meter_model.sv
`timescale 1ns/10ps
// ****
// meter pulse source
// ****
module fpd_meter_model (
	// clock
	input wire clk_in,
	// meter pins
	output reg odd_pin_out,
	output reg even_pin_out
);
	initial begin
		odd_pin_out = 1'b0;
		even_pin_out = 1'b0;
	end
	// 10 clocks per level, so a slowed sampler still sees it twice
	task lv(input [1:0] s);
		begin
			{odd_pin_out, even_pin_out} = s;
			repeat (10) @(posedge clk_in);
			#1;
		end
	endtask
	// n pulses on one pin, the other pin left alone
	task pul(input e, input integer n);
		integer k;
		for (k = 0; k < n; k = k + 1) begin
			lv(e ? {odd_pin_out, 1'b1} : {1'b1, even_pin_out});
			lv(e ? {odd_pin_out, 1'b0} : {1'b0, even_pin_out});
		end
	endtask
endmodule

// file: dv/fpd_flow_pulse_decoder_tb.sv
`timescale 1ns/10ps
// ****
// bench top
// ****
module fpd_flow_pulse_decoder_tb;
	reg clk, nrst, tick, trig, rdy, st;
	reg [2:0] om, em;
	reg [4:0] ch;
	reg [15:0] sdiv;
	reg [23:0] sdur;
	reg [13:0] qseq;
	wire op, ep, vld, clm, err, so, lost;
	wire [4:0] dch;
	wire [16:0] dval;
	integer n_mismatch = 0;
	integer checked = 0;
	integer i;
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	fpd_meter_model u_fpd_meter_model (.clk_in(clk), .odd_pin_out(op), .even_pin_out(ep));
	fpd_flow_pulse_decoder u_fpd_flow_pulse_decoder (.ref_clk_in(clk), .nrst_in(nrst),
		.odd_meter_pin_in(op), .even_meter_pin_in(ep), .odd_mode_in(om), .even_mode_in(em),
		.store_type_in(st), .odd_chan_in(ch), .sample_div_in(sdiv),
		.log_tick_in(tick), .trig_in(trig), .stat_dur_in(sdur), .dp_ready_in(rdy),
		.dp_valid_out(vld), .dp_chan_out(dch), .dp_value_out(dval), .even_claimed_out(clm),
		.cfg_err_out(err), .stat_out(so), .lost_out(lost));
	task summarize;
		begin
			$display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
			if (n_mismatch == 0 && checked > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask
	task chk(input [16:0] s, input [16:0] e);
		begin
			checked = checked + 1;
			if (s !== e) begin
				n_mismatch = n_mismatch + 1;
				$display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
			end
		end
	endtask
	// inputs move 1 ns after the edge
	task cyc(input integer n);
		begin
			repeat (n) @(posedge clk);
			#1;
		end
	endtask
	task tk;
		begin
			tick = 1'b1;
			cyc(1);
			tick = 1'b0;
		end
	endtask
	// clear counters left by the previous mode
	task cfg(input [2:0] o, input [2:0] e, input s);
		begin
			om = o;
			em = e;
			st = s;
			cyc(2);
			tk;
			cyc(8);
		end
	endtask
	task take(input [4:0] c, input [16:0] v);
		begin
			i = 0;
			while (vld !== 1'b1 && i < 20) begin
				cyc(1);
				i = i + 1;
			end
			if (vld !== 1'b1) begin
				n_mismatch = n_mismatch + 1;
				summarize;
			end
			chk({12'h000, dch}, {12'h000, c});
			chk(dval, v);
			cyc(1);
		end
	endtask
	initial begin
		{nrst, tick, trig, st, om, em} = 10'h000;
		rdy = 1'b1;
		ch = 5'h03;
		sdiv = 16'h0003;
		sdur = 24'h000005;
		qseq = 14'h1E2C;
		cyc(4);
		nrst = 1'b1;
		cyc(1);
		cfg(3'h1, 3'h0, 1'b0);
		u_fpd_meter_model.pul(0, 3);
		tk;
		take(5'h03, 17'h00003);
		tk;
		take(5'h03, 17'h00000);
		// even pin alone, tagged one above the configured channel
		ch = 5'h09;
		cfg(3'h0, 3'h1, 1'b0);
		u_fpd_meter_model.pul(1, 2);
		tk;
		take(5'h0A, 17'h00002);
		ch = 5'h03;
		cfg(3'h2, 3'h0, 1'b0);
		chk(clm, 17'h00001);
		u_fpd_meter_model.pul(0, 3);
		u_fpd_meter_model.lv(2'h1);
		u_fpd_meter_model.pul(0, 1);
		u_fpd_meter_model.lv(2'h0);
		tk;
		take(5'h03, 17'h00002);
		// split words with the receiver stalled, then overfilled
		cfg(3'h2, 3'h0, 1'b1);
		u_fpd_meter_model.pul(0, 2);
		u_fpd_meter_model.lv(2'h1);
		u_fpd_meter_model.pul(0, 1);
		u_fpd_meter_model.lv(2'h0);
		rdy = 1'b0;
		tk;
		cyc(8);
		chk(vld, 17'h00001);
		tk;
		cyc(8);
		chk(lost, 17'h00001);
		rdy = 1'b1;
		take(5'h03, 17'h00002);
		take(5'h04, 17'h00001);
		take(5'h04, 17'h00000);
		cfg(3'h3, 3'h0, 1'b0);
		u_fpd_meter_model.pul(0, 2);
		u_fpd_meter_model.pul(1, 3);
		tk;
		take(5'h03, 17'h1FFFF);
		// four forward, two reverse, one double-bit step
		// sampler at full clock rate for the quadrature run
		sdiv = 16'h0000;
		cfg(3'h4, 3'h0, 1'b0);
		for (i = 6; i >= 0; i = i - 1)
			u_fpd_meter_model.lv(qseq[2 * i +: 2]);
		tk;
		take(5'h03, 17'h00002);
		cfg(3'h4, 3'h1, 1'b0);
		chk(err, 17'h00001);
		cfg(3'h5, 3'h0, 1'b0);
		chk(err, 17'h00001);
		cfg(3'h0, 3'h0, 1'b0);
		trig = 1'b1;
		cyc(1);
		trig = 1'b0;
		cyc(1);
		chk(so, 17'h00001);
		// five clocks active: still on at the fourth, off at the fifth
		cyc(3);
		chk(so, 17'h00001);
		cyc(1);
		chk(so, 17'h00000);
		// reset in mid-run clears the sticky loss flag
		nrst = 1'b0;
		cyc(1);
		chk(lost, 17'h00000);
		nrst = 1'b1;
		cyc(2);
		chk(vld, 17'h00000);
		summarize;
	end
endmodule
